// >>> bench/rdeq_i2c_ctl.sv
// Board controller model: I2C controller with register write and read.
// Assumes a pulled-up SDA wire resolved by the bench; no clock stretching.
`timescale 1ns/1ps
module rdeq_i2c_ctl (
    input  wire  mclk,
    input  wire  sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter bit of 4 mclk keeps both SCL phases at 8 cycles
    task automatic wq;
        repeat (4) @(negedge mclk);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_low = !b;
        wq();
        scl = 1'b1;
        wq();
        r = sda;
        wq();
        scl = 1'b0;
        wq();
    endtask
    task automatic start;
        sda_low = 1'b0;
        wq();
        scl = 1'b1;
        wq();
        sda_low = 1'b1;
        wq();
        scl = 1'b0;
        wq();
    endtask
    task automatic stop;
        sda_low = 1'b1;
        wq();
        scl = 1'b1;
        wq();
        sda_low = 1'b0;
        wq();
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                      input int n, output logic ok);
        logic k;
        start();
        tx({a, 1'b0}, ok);
        if (ok) begin
            tx(p, k);
            ok = k;
            for (int i = 0; i < n; i++) begin
                tx(d[8*i +: 8], k);
                ok = ok & k;
            end
        end
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                      output logic [15:0] d, output logic ok);
        logic k;
        logic r;
        d = 16'h0000;
        start();
        tx({a, 1'b0}, ok);
        tx(p, k);
        ok = ok & k;
        start();
        tx({a, 1'b1}, k);
        ok = ok & k;
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) begin
                bitx(1'b1, r);
                d[8*i+j] = r;
            end
            bitx(i == n - 1, r);
        end
        stop();
    endtask
endmodule

// >>> bench/rdeq_regs_asserts.sv
// Checker for the equalization register bank, bound to its top module.
// Assumes SCL phases of several mclk cycles, as the bench drives them.
`timescale 1ns/1ps
module rdeq_regs_chk (
    input wire       mclk,
    input wire       rst_n,
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    input wire [3:0] rx_eq_strap_pins,
    input wire [3:0] tx_side_eq_strap_pins,
    input wire [1:0] addr_strap_hi,
    input wire       eq_source_register_flag,
    input wire       flip_select,
    input wire       channel_enable,
    input wire [3:0] rx_path1_eq_level,
    input wire [3:0] rx_path2_eq_level,
    input wire [3:0] tx_side_eq_level
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RST_VAL: assert property ($rose(rst_n) |-> channel_enable && !flip_select
        && !eq_source_register_flag && rx_path1_eq_level == 4'h0)
        else $error("reset values wrong");
    AST_GEN_STABLE: assert property (scl_in |->
        $stable({eq_source_register_flag, flip_select, channel_enable}))
        else $error("general bits moved with SCL high");
    AST_OVR_HOLD: assert property (eq_source_register_flag && $past(eq_source_register_flag)
        && scl_in |-> $stable({rx_path1_eq_level, rx_path2_eq_level, tx_side_eq_level}))
        else $error("levels moved under override");
    AST_RX1_FOLLOW: assert property ((!eq_source_register_flag && $stable(rx_eq_strap_pins)) [*5]
        |-> rx_path1_eq_level == rx_eq_strap_pins)
        else $error("path 1 level not following straps");
    AST_RX2_FOLLOW: assert property ((!eq_source_register_flag && $stable(rx_eq_strap_pins)) [*5]
        |-> rx_path2_eq_level == rx_eq_strap_pins)
        else $error("path 2 level not following straps");
    AST_TX_FOLLOW: assert property ((!eq_source_register_flag && $stable(tx_side_eq_strap_pins)) [*5]
        |-> tx_side_eq_level == tx_side_eq_strap_pins)
        else $error("tx-side level not following straps");
    AST_OE_EDGE: assert property ($rose(sda_oe) || $fell(sda_oe) |-> !scl_in)
        else $error("SDA changed while SCL high");
    AST_OD_LOW: assert property (sda_oe |-> sda_out == 1'b0 && !sda_in)
        else $error("SDA driven high");
    cover property ($rose(eq_source_register_flag));
    cover property ($fell(channel_enable));
    cover property ($rose(sda_oe));
endmodule
bind rdeq_config_regs rdeq_regs_chk rdeq_regs_chk_i (.mclk, .rst_n, .scl_in, .sda_in,
    .sda_out, .sda_oe, .rx_eq_strap_pins, .tx_side_eq_strap_pins, .addr_strap_hi,
    .eq_source_register_flag, .flip_select, .channel_enable, .rx_path1_eq_level,
    .rx_path2_eq_level, .tx_side_eq_level);

// >>> bench/testbench.sv
// Self-checking bench for the equalization register bank over I2C.
// Assumes both address straps float, giving the default target address.
`timescale 1ns/1ps
`include "rdeq_map.vh"
module testbench;
    localparam logic [6:0] A = `RDEQ_TGT_ADDR_FLOAT;
    logic        mclk = 1'b0;
    logic        rst_n;
    logic [3:0]  rx_strap;
    logic [3:0]  tx_strap;
    logic [1:0]  a_hi;
    wire         scl;
    wire         sda_low;
    wire         sda_out;
    wire         sda_oe;
    wire         sda;
    wire         ovr;
    wire         flip;
    wire         en;
    wire  [3:0]  rx1;
    wire  [3:0]  rx2;
    wire  [3:0]  txl;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [15:0] d;
    logic        ok;
    assign sda = !((sda_oe && !sda_out) || sda_low);
    always #50 mclk = ~mclk;
    rdeq_config_regs rdeq_config_regs_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .rx_eq_strap_pins(rx_strap),
        .tx_side_eq_strap_pins(tx_strap), .addr_strap_hi(a_hi),
        .eq_source_register_flag(ovr), .flip_select(flip), .channel_enable(en),
        .rx_path1_eq_level(rx1), .rx_path2_eq_level(rx2), .tx_side_eq_level(txl));
    rdeq_i2c_ctl rdeq_i2c_ctl_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic tally_and_finish;
        $display("Comparisons: %0d, mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] p, input int n, input logic [15:0] exp);
        rdeq_i2c_ctl_i.rd(A, p, n, d, ok);
        chk({3'h0, ok, d}, {4'h1, exp});
    endtask
    task automatic wchk(input logic [6:0] a, input logic [7:0] p, input int n,
                        input logic [15:0] v, input logic exp_ok);
        rdeq_i2c_ctl_i.wr(a, p, v, n, ok);
        chk({19'h0, ok}, {19'h0, exp_ok});
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        rx_strap = 4'h9;
        tx_strap = 4'h6;
        a_hi = 2'h2;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        repeat (12) @(negedge mclk);
        chk({5'h0, ovr, flip, en, rx1, rx2, txl}, {5'h0, 3'b001, 12'h996});
        rchk(`RDEQ_OFS_GEN, 1, 16'h0001);
        rchk(`RDEQ_OFS_RXEQ, 2, 16'h0699);
        wchk(A, `RDEQ_OFS_RXEQ, 1, 16'h005A, 1'b1);
        rchk(`RDEQ_OFS_RXEQ, 1, 16'h0099);
        wchk(7'h13, `RDEQ_OFS_GEN, 1, 16'h0000, 1'b0);
        rchk(`RDEQ_OFS_GEN, 1, 16'h0001);
        wchk(A, `RDEQ_OFS_GEN, 1, 16'h00FF, 1'b1);
        rchk(`RDEQ_OFS_GEN, 1, 16'h001F);
        chk({17'h0, ovr, flip, en}, {17'h0, 3'b111});
        wchk(A, `RDEQ_OFS_GEN, 1, 16'h0014, 1'b1);
        chk({17'h0, ovr, flip, en}, {17'h0, 3'b110});
        wchk(A, `RDEQ_OFS_RXEQ, 2, 16'hF3A5, 1'b1);
        rx_strap = 4'h3;
        tx_strap = 4'hA;
        repeat (8) @(negedge mclk);
        rchk(`RDEQ_OFS_RXEQ, 2, 16'h03A5);
        chk({8'h0, rx1, rx2, txl}, {8'h0, 12'h5A3});
        wchk(A, `RDEQ_OFS_GEN, 1, 16'h0001, 1'b1);
        repeat (8) @(negedge mclk);
        rchk(`RDEQ_OFS_RXEQ, 2, 16'h0A33);
        chk({8'h0, rx1, rx2, txl}, {8'h0, 12'h33A});
        rchk(8'h0B, 1, 16'h0000);
        tally_and_finish();
    end
endmodule

// >>> inc/rdeq_map.vh
// Register map, field positions, reset values and I2C constants for the
// redriver equalization configuration bank. Definitions only.
// Notes on behaviour
// R01: General bit 4 chooses EQ source: 0 strap pins, 1 programmed register fields.
// R02: General bit 2 selects orientation: 0 normal, 1 flipped; resets to 0.
// R03: General bit 0 enables all channels; register resets to 0x01.
// R04: General bits 7:5 read-only zero; bits 3 and 1 plain read/write, reset 0.
// R05: First EQ register upper nibble: path 2 level, strap-driven unless override set.
// R06: First EQ register lower nibble: path 1 level, same strap/override behaviour.
// R07: Second EQ register bits 3:0 transmit-side level; bits 7:4 read zero.
// R08: Set-type fields become one on a written one; zero leaves them alone.
// R09: Clear-type fields become zero on a written one; zero leaves them alone.
// R10: Updatable fields change from hardware without any software write.
// R11: Responds as I2C target; address 0x12 with both address straps floating.
// R12: Clearing the override makes EQ fields follow the strap pins again.
`ifndef RDEQ_MAP_VH
`define RDEQ_MAP_VH

`define RDEQ_OFS_GEN          8'h0A
`define RDEQ_OFS_RXEQ         8'h20
`define RDEQ_OFS_TXEQ         8'h21

`define RDEQ_RST_GEN          8'h01
`define RDEQ_RST_RXEQ         8'h00
`define RDEQ_RST_TXEQ         8'h00

`define RDEQ_BIT_EN           0
`define RDEQ_BIT_FLIP         2
`define RDEQ_BIT_OVR          4

// Per-register write masks: plain, write-one-to-set, write-one-to-clear
`define RDEQ_RW_GEN           8'h1F
`define RDEQ_RW_RXEQ          8'hFF
`define RDEQ_RW_TXEQ          8'h0F
`define RDEQ_SET_ANY          8'h00
`define RDEQ_CLR_ANY          8'h00

`define RDEQ_TGT_ADDR_FLOAT   7'h12
`define RDEQ_LEVEL_FLOAT      2'h2

`endif

// >>> rtl/rdeq_config_regs.v
// Equalization configuration register bank reached as an I2C target.
// Assumes SCL/SDA and strap pins are asynchronous to mclk and SCL runs
// well below mclk/8; an external pull-up sets the SDA idle level.
`timescale 1ns/1ps
`include "rdeq_map.vh"

module rdeq_config_regs (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    input  wire [3:0] rx_eq_strap_pins,
    input  wire [3:0] tx_side_eq_strap_pins,
    input  wire [1:0] addr_strap_hi,
    output wire       eq_source_register_flag,
    output wire       flip_select,
    output wire       channel_enable,
    output wire [3:0] rx_path1_eq_level,
    output wire [3:0] rx_path2_eq_level,
    output wire [3:0] tx_side_eq_level
);

    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_ADDR  = 4'h1;
    localparam [3:0] ST_AACK  = 4'h2;
    localparam [3:0] ST_PTR   = 4'h3;
    localparam [3:0] ST_PACK  = 4'h4;
    localparam [3:0] ST_WDATA = 4'h5;
    localparam [3:0] ST_WACK  = 4'h6;
    localparam [3:0] ST_RDATA = 4'h7;
    localparam [3:0] ST_RACK  = 4'h8;
    localparam [3:0] ST_WAIT  = 4'h9;

    // Full reset word kept so its field can be sliced at the right width
    localparam [7:0] TX_RST_WORD = `RDEQ_RST_TXEQ;

    reg  [7:0] gen_ctl;
    reg  [7:0] rx_eq;
    reg  [3:0] tx_eq;

    reg  [1:0] scl_sync;
    reg  [1:0] sda_sync;
    reg        scl_d;
    reg        sda_d;
    reg  [3:0] rx_strap_m;
    reg  [3:0] rx_strap_s;
    reg  [3:0] tx_strap_m;
    reg  [3:0] tx_strap_s;
    reg  [1:0] ahi_m;
    reg  [1:0] ahi_s;
    reg  [1:0] cap_cnt;
    reg  [6:0] my_addr;

    reg  [3:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] shreg;
    reg  [7:0] txsh;
    reg  [7:0] ptr;
    reg        rw_bit;
    reg        mack;
    reg        wr_stb;
    reg  [7:0] wr_ofs;
    reg  [7:0] wr_dat;

    wire scl_s     = scl_sync[1];
    wire sda_s     = sda_sync[1];
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire ovr       = gen_ctl[`RDEQ_BIT_OVR];

    assign sda_out                 = 1'b0;
    assign eq_source_register_flag = gen_ctl[`RDEQ_BIT_OVR];    // see R01
    assign flip_select             = gen_ctl[`RDEQ_BIT_FLIP];   // see R02
    assign channel_enable          = gen_ctl[`RDEQ_BIT_EN];     // see R03
    assign rx_path2_eq_level       = rx_eq[7:4];
    assign rx_path1_eq_level       = rx_eq[3:0];
    assign tx_side_eq_level        = tx_eq;

    // Plain bits take the data; set and clear kinds act on ones only
    function [7:0] apply_write;
        input [7:0] old;
        input [7:0] wd;
        input [7:0] rw_mask;
        begin
            apply_write = ((old & ~rw_mask) | (wd & rw_mask) | (wd & `RDEQ_SET_ANY))
                          & ~(wd & `RDEQ_CLR_ANY);                  // see R08 see R09
        end
    endfunction

    // Arguments only, so a continuous assignment sees every change
    wire [7:0] next_tx_eq = apply_write({4'h0, tx_eq}, wr_dat, `RDEQ_RW_TXEQ);

    // Unmapped offsets read as zero
    function [7:0] read_reg;
        input [7:0] ofs;
        begin
            case (ofs)
                `RDEQ_OFS_GEN:  read_reg = {3'h0, gen_ctl[4:0]};     // see R04
                `RDEQ_OFS_RXEQ: read_reg = rx_eq;
                `RDEQ_OFS_TXEQ: read_reg = {4'h0, tx_eq};           // see R07
                default:        read_reg = 8'h00;
            endcase
        end
    endfunction

    // Pin synchronisers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync   <= 2'h3;
            sda_sync   <= 2'h3;
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
            rx_strap_m <= 4'h0;
            rx_strap_s <= 4'h0;
            tx_strap_m <= 4'h0;
            tx_strap_s <= 4'h0;
            ahi_m      <= 2'h0;
            ahi_s      <= 2'h0;
        end else begin
            scl_sync   <= {scl_sync[0], scl_in};
            sda_sync   <= {sda_sync[0], sda_in};
            scl_d      <= scl_s;
            sda_d      <= sda_s;
            rx_strap_m <= rx_eq_strap_pins;
            rx_strap_s <= rx_strap_m;
            tx_strap_m <= tx_side_eq_strap_pins;
            tx_strap_s <= tx_strap_m;
            ahi_m      <= addr_strap_hi;
            ahi_s      <= ahi_m;
        end
    end

    // Address straps latched once the synchronisers hold real pin levels
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt <= 2'h0;
            my_addr <= `RDEQ_TGT_ADDR_FLOAT;
        end else if (cap_cnt != 2'h3) begin
            cap_cnt <= cap_cnt + 2'h1;
            if (cap_cnt == 2'h2) begin
                my_addr <= `RDEQ_TGT_ADDR_FLOAT ^ {3'h0, ahi_s ^ `RDEQ_LEVEL_FLOAT,
                           tx_strap_s[1:0] ^ `RDEQ_LEVEL_FLOAT};    // see R11
            end
        end
    end

    // Register bank
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gen_ctl <= `RDEQ_RST_GEN;                               // see R03
            rx_eq   <= `RDEQ_RST_RXEQ;
            tx_eq   <= TX_RST_WORD[3:0];
        end else begin
            if (wr_stb && wr_ofs == `RDEQ_OFS_GEN) begin
                gen_ctl <= apply_write(gen_ctl, wr_dat, `RDEQ_RW_GEN);   // see R01 see R04
            end
            // Strap levels win while the override is clear, so writes are lost
            if (!ovr) begin
                rx_eq <= {rx_strap_s, rx_strap_s};                  // see R05 see R06 see R10
                tx_eq <= tx_strap_s;                                // see R07 see R12
            end else if (wr_stb && wr_ofs == `RDEQ_OFS_RXEQ) begin
                rx_eq <= apply_write(rx_eq, wr_dat, `RDEQ_RW_RXEQ); // see R05 see R06
            end else if (wr_stb && wr_ofs == `RDEQ_OFS_TXEQ) begin
                tx_eq <= next_tx_eq[3:0];                           // see R07
            end
        end
    end

    // I2C target: sample on SCL rise, change SDA after SCL fall
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            txsh    <= 8'h00;
            ptr     <= 8'h00;
            rw_bit  <= 1'b0;
            mack    <= 1'b0;
            sda_oe  <= 1'b0;
            wr_stb  <= 1'b0;
            wr_ofs  <= 8'h00;
            wr_dat  <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_det) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop_det) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        shreg   <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RACK: begin
                        mack <= ~sda_s;
                    end
                    default: begin
                        bit_cnt <= bit_cnt;
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == my_addr) begin        // see R11
                                rw_bit <= shreg[0];
                                sda_oe <= 1'b1;
                                state  <= ST_AACK;
                            end else begin
                                state <= ST_WAIT;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_cnt <= 4'h0;
                        if (rw_bit) begin
                            txsh   <= read_reg(ptr);
                            sda_oe <= ~|(read_reg(ptr) & 8'h80);
                            state  <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (bit_cnt == 4'h8) begin
                            ptr    <= shreg;
                            sda_oe <= 1'b1;
                            state  <= ST_PACK;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt == 4'h8) begin
                            wr_stb <= 1'b1;
                            wr_ofs <= ptr;
                            wr_dat <= shreg;
                            ptr    <= ptr + 8'h01;
                            sda_oe <= 1'b1;
                            state  <= ST_WACK;
                        end
                    end
                    ST_PACK, ST_WACK: begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            ptr    <= ptr + 8'h01;
                            state  <= ST_RACK;
                        end else begin
                            sda_oe <= ~txsh[6];
                            txsh   <= {txsh[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (mack) begin
                            txsh   <= read_reg(ptr);
                            sda_oe <= ~|(read_reg(ptr) & 8'h80);
                            state  <= ST_RDATA;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
